// *** opdec_regs.svh ***
// Opcode values, field values and clock counts for the opcode decoder
`ifndef OPDEC_REGS_SVH
`define OPDEC_REGS_SVH
`define OP_ESCAPE 8'h0f
`define OP2_STORE_LT 8'h9c
`define OP2_STORE_LE 8'h9e
`define OP2_STORE_GT 8'h9f
`define OP_FRAME_BUILD 8'hc8
`define OP_FRAME_TEARDOWN 8'hc9
`define OP_TRAP_VEC 8'hcd
`define OP_TRAP_BRK 8'hcc
`define OP_TRAP_OVF 8'hce
`define OP_RANGE_CHECK 8'h62
`define OP2_CR_READ 8'h20
`define OP2_DR_READ 8'h21
`define OP2_DR_WRITE 8'h23
`define OP2_TR_READ 8'h24
`define OP2_TR_WRITE 8'h26
`define OP_IDLE 8'h90
`define OP_COPROC_SYNC 8'h9b
`define OP_COPROC_MASK 8'hf8
`define OP_COPROC_BASE 8'hd8
`define OP_BUS_HOLD 8'hf0
`define OP_ADDR_SIZE 8'h67
`define OP_OPER_SIZE 8'h66
`define OP_SEG_CS 8'h2e
`define OP_SEG_DS 8'h3e
`define OP_SEG_ES 8'h26
`define OP_SEG_FS 8'h64
`define OP_SEG_GS 8'h65
`define OP_SEG_SS 8'h36
`define OP_PRIV_ADJUST 8'h63
`define OP2_ACCESS_RIGHTS 8'h02
`define OP2_TABLE_GRP 8'h01
`define OP2_LOCAL_GRP 8'h00
`define SEL_ZERO 3'h0
`define SEL_GLOBAL 3'h2
`define SEL_VECTOR 3'h3
`define SEL_STATUS 3'h6
`define FORM_REG 2'h3
`define VEC_BREAK 8'h03
`define VEC_OVERFLOW 8'h04
`define VEC_RANGE 8'h05
`define VEC_INVALID 8'h06
`define VEC_GENPROT 8'h0d
`define CLK_STORE_REG 9'd4
`define CLK_STORE_MEM 9'd5
`define CLK_FRAME_L0 9'd10
`define CLK_FRAME_L1 9'd12
`define CLK_FRAME_BASE 9'd15
`define CLK_FRAME_STEP 9'd4
`define CLK_TEARDOWN 9'd4
`define CLK_TRAP_VEC 9'd37
`define CLK_TRAP_BRK 9'd33
`define CLK_TRAP_OVF 9'd35
`define CLK_TRAP_OVF_NONE 9'd3
`define CLK_RANGE_OUT 9'd44
`define CLK_RANGE_IN 9'd10
`define CLK_PM_SAME 9'd59
`define CLK_PM_CHANGE 9'd99
`define CLK_CR_READ 9'd6
`define CLK_DR_WRITE_LO 9'd22
`define CLK_DR_WRITE_HI 9'd16
`define CLK_DR_READ_HI 9'd14
`define CLK_DR_READ_LO 9'd22
`define CLK_TR 9'd12
`define CLK_IDLE 9'd3
`define CLK_SYNC 9'd7
`define CLK_PRIV_REG 9'd20
`define CLK_PRIV_MEM 9'd21
`define CLK_RIGHTS_REG 9'd15
`define CLK_RIGHTS_MEM 9'd16
`define CLK_TABLE 9'd11
`define CLK_LOCAL_REG 9'd20
`define CLK_LOCAL_MEM 9'd24
`define CLK_STATUS_REG 9'd11
`define CLK_STATUS_MEM 9'd14
`define CLK_FAULT 9'd1
`define CLK_DEFAULT 9'd2
`endif

// *** opdec_pkg.sv ***
// Types shared by the opcode decoder
package opdec_pkg;
    typedef enum logic [4:0] {
        K_NONE, K_STORE, K_FRAME_BUILD, K_FRAME_TEARDOWN, K_TRAP, K_RANGE,
        K_CR_READ, K_DR_READ, K_DR_WRITE, K_TR_READ, K_TR_WRITE, K_IDLE,
        K_SYNC, K_COPROC, K_PRIV_ADJUST, K_RIGHTS, K_GLOBAL, K_VECTOR,
        K_LOCAL, K_STATUS, K_OTHER
    } op_kind_e;
    typedef struct packed {
        logic bus_hold;
        logic addr_flip;
        logic oper_flip;
        logic seg_valid;
        logic [2:0] seg;
    } prefix_s;
    typedef struct packed {
        op_kind_e kind;
        logic [8:0] clocks;
        logic trap;
        logic [7:0] vector;
        logic [2:0] coproc_op_hi;
        logic [2:0] coproc_op_lo;
        prefix_s prefix;
    } issue_s;
endpackage

// *** opdec_core.sv ***
// Opcode decoder with clock-count sequencing for a 32-bit processor
`timescale 1ns/1ns
`default_nettype none
`include "opdec_regs.svh"
module opdec_core
    import opdec_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic byte_ready,
    input wire logic protected_mode,
    input wire logic overflow_flag,
    input wire logic range_out,
    input wire logic gate_priv_change,
    input wire logic [1:0] current_privilege,
    input wire logic [1:0] io_privilege_ceiling,
    input wire logic coproc_busy_pin,
    output issue_s issue,
    output logic issue_valid,
    output logic busy,
    output logic bus_lock,
    output logic done
);
    typedef enum logic [2:0] {S_OP, S_OP2, S_MODRM, S_IMM, S_EXEC} state_e;
    state_e state;
    logic [7:0] op;
    logic [7:0] op2;
    logic escaped;
    logic [1:0] imm_left;
    logic [7:0] level;
    logic [8:0] count;
    logic waiting_sync;
    prefix_s pre;
    logic busy_meta;
    logic busy_sync;

    function automatic logic is_prefix(input logic [7:0] b);
        is_prefix = (b == `OP_BUS_HOLD) || (b == `OP_ADDR_SIZE) || (b == `OP_OPER_SIZE) ||
            (b == `OP_SEG_CS) || (b == `OP_SEG_DS) || (b == `OP_SEG_ES) ||
            (b == `OP_SEG_FS) || (b == `OP_SEG_GS) || (b == `OP_SEG_SS);
    endfunction

    function automatic logic [2:0] seg_code(input logic [7:0] b);
        case (b)
            `OP_SEG_ES: seg_code = 3'h0;
            `OP_SEG_CS: seg_code = 3'h1;
            `OP_SEG_SS: seg_code = 3'h2;
            `OP_SEG_DS: seg_code = 3'h3;
            `OP_SEG_FS: seg_code = 3'h4;
            default: seg_code = 3'h5;
        endcase
    endfunction

    // Two flops on the coprocessor busy pin before anything looks at it
    always_ff @(posedge clk) begin
        busy_meta <= coproc_busy_pin;
        busy_sync <= busy_meta;
    end

    wire logic [7:0] b = byte_data;
    wire logic take = byte_valid && byte_ready;
    wire logic [1:0] form = b[7:6];
    wire logic [2:0] sel = b[5:3];
    wire logic is_reg = (form == `FORM_REG);
    wire logic coproc = ((op & `OP_COPROC_MASK) == `OP_COPROC_BASE);
    wire logic needs_modrm_1 = coproc || (op == `OP_RANGE_CHECK) ||
        (op == `OP_PRIV_ADJUST);
    wire logic [8:0] frame_clocks = (level == 8'h00) ? `CLK_FRAME_L0 :
        (level == 8'h01) ? `CLK_FRAME_L1 :
        9'(`CLK_FRAME_BASE + `CLK_FRAME_STEP * ({1'b0, level} - 9'd1));
    wire logic [8:0] trap_clocks = protected_mode ?
        (gate_priv_change ? `CLK_PM_CHANGE : `CLK_PM_SAME) : 9'd0;
    wire logic lock_fault = pre.bus_hold &&
        (current_privilege > io_privilege_ceiling);

    // Classification of a finished instruction from opcode and addressing byte
    op_kind_e k;
    logic [8:0] c;
    logic tr;
    logic [7:0] v;
    logic pm_only;
    always_comb begin
        k = K_OTHER;
        c = `CLK_DEFAULT;
        tr = 1'b0;
        v = 8'h00;
        pm_only = 1'b0;
        if (escaped) begin
            case (op2)
                `OP2_STORE_LT, `OP2_STORE_LE, `OP2_STORE_GT: begin
                    if (sel == `SEL_ZERO) begin
                        k = K_STORE;
                        c = is_reg ? `CLK_STORE_REG : `CLK_STORE_MEM;
                    end
                end
                `OP2_CR_READ: begin
                    k = K_CR_READ;
                    c = `CLK_CR_READ;
                end
                `OP2_DR_WRITE: begin
                    k = K_DR_WRITE;
                    c = sel[2] ? `CLK_DR_WRITE_HI : `CLK_DR_WRITE_LO;
                end
                `OP2_DR_READ: begin
                    k = K_DR_READ;
                    c = sel[2] ? `CLK_DR_READ_HI : `CLK_DR_READ_LO;
                end
                `OP2_TR_WRITE, `OP2_TR_READ: begin
                    k = (op2 == `OP2_TR_WRITE) ? K_TR_WRITE : K_TR_READ;
                    c = `CLK_TR;
                end
                `OP2_ACCESS_RIGHTS: begin
                    k = K_RIGHTS;
                    c = is_reg ? `CLK_RIGHTS_REG : `CLK_RIGHTS_MEM;
                    pm_only = 1'b1;
                end
                `OP2_TABLE_GRP: begin
                    if (sel == `SEL_GLOBAL || sel == `SEL_VECTOR) begin
                        k = (sel == `SEL_GLOBAL) ? K_GLOBAL : K_VECTOR;
                        c = `CLK_TABLE;
                    end else if (sel == `SEL_STATUS) begin
                        k = K_STATUS;
                        c = is_reg ? `CLK_STATUS_REG : `CLK_STATUS_MEM;
                    end
                end
                `OP2_LOCAL_GRP: begin
                    if (sel == `SEL_GLOBAL) begin
                        k = K_LOCAL;
                        c = is_reg ? `CLK_LOCAL_REG : `CLK_LOCAL_MEM;
                        pm_only = 1'b1;
                    end
                end
                default: k = K_OTHER;
            endcase
        end else if (coproc) begin
            k = K_COPROC;
        end else if (op == `OP_RANGE_CHECK) begin
            k = K_RANGE;
            tr = range_out;
            v = `VEC_RANGE;
            c = range_out ? `CLK_RANGE_OUT : `CLK_RANGE_IN;
        end else if (op == `OP_PRIV_ADJUST) begin
            k = K_PRIV_ADJUST;
            c = is_reg ? `CLK_PRIV_REG : `CLK_PRIV_MEM;
            pm_only = 1'b1;
        end else begin
            case (op)
                `OP_FRAME_BUILD: begin
                    k = K_FRAME_BUILD;
                    c = frame_clocks;
                end
                `OP_FRAME_TEARDOWN: begin
                    k = K_FRAME_TEARDOWN;
                    c = `CLK_TEARDOWN;
                end
                `OP_TRAP_VEC: begin
                    k = K_TRAP;
                    tr = 1'b1;
                    v = level;
                    c = protected_mode ? trap_clocks : `CLK_TRAP_VEC;
                end
                `OP_TRAP_BRK: begin
                    k = K_TRAP;
                    tr = 1'b1;
                    v = `VEC_BREAK;
                    c = protected_mode ? trap_clocks : `CLK_TRAP_BRK;
                end
                `OP_TRAP_OVF: begin
                    k = K_TRAP;
                    tr = overflow_flag;
                    v = `VEC_OVERFLOW;
                    c = overflow_flag ? (protected_mode ? trap_clocks : `CLK_TRAP_OVF) :
                        `CLK_TRAP_OVF_NONE;
                end
                `OP_IDLE: begin
                    k = K_IDLE;
                    c = `CLK_IDLE;
                end
                `OP_COPROC_SYNC: begin
                    k = K_SYNC;
                    c = `CLK_SYNC;
                end
                default: k = K_OTHER;
            endcase
        end
        if (pm_only && !protected_mode) begin
            tr = 1'b1;
            v = `VEC_INVALID;
            c = `CLK_FAULT;
        end
        if (lock_fault) begin
            tr = 1'b1;
            v = `VEC_GENPROT;
            c = `CLK_FAULT;
        end
    end

    // Instructions that finish on a byte: single-byte forms end on the opcode
    wire logic single = !escaped && !needs_modrm_1;
    assign byte_ready = (state != S_EXEC);
    assign busy = (state == S_EXEC);
    assign bus_lock = pre.bus_hold && (state != S_OP);
    assign done = (state == S_EXEC) && (count == 9'd1) && !(waiting_sync && busy_sync);

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= S_OP;
            op <= 8'h00;
            op2 <= 8'h00;
            escaped <= 1'b0;
            imm_left <= 2'h0;
            level <= 8'h00;
            count <= 9'd0;
            waiting_sync <= 1'b0;
            pre <= '0;
            issue <= '0;
            issue_valid <= 1'b0;
        end else begin
            issue_valid <= 1'b0;
            case (state)
                S_OP: begin
                    if (take) begin
                        if (is_prefix(b)) begin
                            // Prefixes add no clocks and stack up until an opcode arrives
                            if (b == `OP_BUS_HOLD) pre.bus_hold <= 1'b1;
                            if (b == `OP_ADDR_SIZE) pre.addr_flip <= 1'b1;
                            if (b == `OP_OPER_SIZE) pre.oper_flip <= 1'b1;
                            if (!(b == `OP_BUS_HOLD || b == `OP_ADDR_SIZE ||
                                  b == `OP_OPER_SIZE)) begin
                                pre.seg_valid <= 1'b1;
                                pre.seg <= seg_code(b);
                            end
                        end else begin
                            op <= b;
                            escaped <= (b == `OP_ESCAPE);
                            level <= 8'h00;
                            if (b == `OP_ESCAPE) begin
                                state <= S_OP2;
                            end else if (b == `OP_FRAME_BUILD) begin
                                imm_left <= 2'h3;
                                state <= S_IMM;
                            end else if (b == `OP_TRAP_VEC) begin
                                imm_left <= 2'h1;
                                state <= S_IMM;
                            end else if ((b & `OP_COPROC_MASK) == `OP_COPROC_BASE ||
                                         b == `OP_RANGE_CHECK || b == `OP_PRIV_ADJUST) begin
                                state <= S_MODRM;
                            end else begin
                                state <= S_EXEC;
                                count <= 9'd0;
                            end
                        end
                    end
                end
                S_OP2: begin
                    if (take) begin
                        op2 <= b;
                        state <= S_MODRM;
                    end
                end
                S_MODRM: begin
                    if (take) begin
                        issue.kind <= k;
                        issue.clocks <= c;
                        issue.trap <= tr;
                        issue.vector <= v;
                        issue.coproc_op_hi <= coproc ? op[2:0] : 3'h0;
                        issue.coproc_op_lo <= coproc ? sel : 3'h0;
                        issue.prefix <= pre;
                        issue_valid <= 1'b1;
                        count <= c;
                        waiting_sync <= 1'b0;
                        state <= S_EXEC;
                    end
                end
                S_IMM: begin
                    if (take) begin
                        // Last immediate byte is the level or the vector
                        imm_left <= imm_left - 2'h1;
                        if (imm_left == 2'h1) begin
                            level <= b;
                            state <= S_EXEC;
                            count <= 9'd0;
                        end
                    end
                end
                S_EXEC: begin
                    if (count == 9'd0) begin
                        // Single-byte and immediate forms issue one cycle after decode
                        issue.kind <= k;
                        issue.clocks <= c;
                        issue.trap <= tr;
                        issue.vector <= v;
                        issue.coproc_op_hi <= 3'h0;
                        issue.coproc_op_lo <= 3'h0;
                        issue.prefix <= pre;
                        issue_valid <= 1'b1;
                        count <= c;
                        waiting_sync <= single && (op == `OP_COPROC_SYNC);
                    end else if (done) begin
                        state <= S_OP;
                        pre <= '0;
                        escaped <= 1'b0;
                    end else if (!(count == 9'd1 && waiting_sync)) begin
                        count <= count - 9'd1;
                    end
                end
                default: state <= S_OP;
            endcase
        end
    end

    // Sync holds its last clock while busy is high
    property p_sync_stall;
        @(posedge clk) disable iff (srst)
        (state == S_EXEC && waiting_sync && count == 9'd1 && busy_sync) |-> !done;
    endproperty
    a_sync_stall: assert property (p_sync_stall) else $error("sync ended while busy");

    property p_teardown_clocks;
        @(posedge clk) disable iff (srst)
        (issue_valid && issue.kind == K_FRAME_TEARDOWN && !issue.trap) |->
            issue.clocks == 9'd4;
    endproperty
    a_teardown_clocks: assert property (p_teardown_clocks) else $error("teardown cost");

    property p_idle_len;
        @(posedge clk) disable iff (srst)
        (issue_valid && issue.kind == K_IDLE && !issue.trap) |-> ##2 done;
    endproperty
    a_idle_len: assert property (p_idle_len) else $error("idle length wrong");

    property p_brk_vector;
        @(posedge clk) disable iff (srst)
        (issue_valid && issue.kind == K_TRAP && $past(op) == `OP_TRAP_BRK &&
            !$past(pre.bus_hold)) |-> issue.vector == 8'h03;
    endproperty
    a_brk_vector: assert property (p_brk_vector) else $error("break vector wrong");

    property p_lock_held;
        @(posedge clk) disable iff (srst)
        (busy && count != 9'd0 && issue.prefix.bus_hold) |-> bus_lock;
    endproperty
    a_lock_held: assert property (p_lock_held) else $error("lock dropped");

    property p_prefix_clear;
        @(posedge clk) disable iff (srst)
        done |=> (pre == '0);
    endproperty
    a_prefix_clear: assert property (p_prefix_clear) else $error("prefix kept");

    property p_real_invalid;
        @(posedge clk) disable iff (srst)
        (issue_valid && !protected_mode && !issue.prefix.bus_hold &&
            (issue.kind == K_PRIV_ADJUST || issue.kind == K_RIGHTS || issue.kind == K_LOCAL))
            |-> issue.trap && issue.vector == 8'h06;
    endproperty
    a_real_invalid: assert property (p_real_invalid) else $error("no invalid fault");

    property p_store_clocks;
        @(posedge clk) disable iff (srst)
        (issue_valid && issue.kind == K_STORE && !issue.trap) |->
            (issue.clocks == 9'd4 || issue.clocks == 9'd5);
    endproperty
    a_store_clocks: assert property (p_store_clocks) else $error("store cost");
endmodule
`default_nettype wire

// *** cpu_opcode_decode_timing_test.sv ***
// Self-checking testbench for the opcode decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cpu_opcode_decode_timing_test;
    import opdec_pkg::*;
    typedef struct {
        logic [39:0] b;
        int n;
        logic [3:0] ctl;
        op_kind_e k;
        logic [8:0] c;
        logic tr;
        logic [7:0] v;
    } row_s;
    logic clk, srst, byte_valid, byte_ready, protected_mode, overflow_flag, range_out;
    logic gate_priv_change, coproc_busy_pin, issue_valid, busy, bus_lock, done, lk;
    logic [7:0] byte_data;
    logic [1:0] current_privilege, io_privilege_ceiling;
    issue_s issue, got;
    int err_count = 0;
    int cmp_count = 0;
    int gap;
    row_s rows[$];
    logic [7:0] segs[6] = '{8'h26, 8'h2e, 8'h36, 8'h3e, 8'h64, 8'h65};

    opdec_core dut (.clk(clk), .srst(srst), .byte_valid(byte_valid), .byte_data(byte_data),
        .byte_ready(byte_ready), .protected_mode(protected_mode),
        .overflow_flag(overflow_flag), .range_out(range_out),
        .gate_priv_change(gate_priv_change), .current_privilege(current_privilege),
        .io_privilege_ceiling(io_privilege_ceiling), .coproc_busy_pin(coproc_busy_pin),
        .issue(issue), .issue_valid(issue_valid), .busy(busy), .bus_lock(bus_lock),
        .done(done));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    function automatic void add(logic [39:0] b, int n, logic [3:0] ctl, op_kind_e k,
                                logic [8:0] c, logic tr, logic [7:0] v);
        rows.push_back('{b, n, ctl, k, c, tr, v});
    endfunction

    task automatic report_and_stop();
        $display("counts: compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Holds the byte until the edge at which the decoder takes it
    task automatic put(input logic [7:0] v);
        int w;
        w = 0;
        byte_valid <= 1'b1;
        byte_data <= v;
        @(posedge clk);
        while (byte_ready !== 1'b1 && w < 400) begin
            w++;
            @(posedge clk);
        end
        if (byte_ready !== 1'b1) err_count++;
    endtask

    // Gap from the issue pulse to the done pulse is clocks minus one, plus any cycles a sync stalls on busy
    task automatic run(input logic [39:0] b, input int n);
        int w;
        w = 0;
        for (int i = 0; i < n; i++) put(b[8*(n-1-i) +: 8]);
        byte_valid <= 1'b0;
        do begin
            @(posedge clk);
            w++;
        end while (issue_valid !== 1'b1 && w < 20);
        if (issue_valid !== 1'b1) err_count++;
        got = issue;
        gap = 0;
        lk = bus_lock;
        while (done !== 1'b1 && gap < 400) begin
            @(posedge clk);
            gap++;
            lk = bus_lock;
        end
        if (done !== 1'b1) err_count++;
    endtask

    initial begin
        srst = 1'b1;
        byte_valid = 1'b0;
        byte_data = 8'h00;
        {protected_mode, overflow_flag, range_out, gate_priv_change} = 4'h0;
        current_privilege = 2'h0;
        io_privilege_ceiling = 2'h0;
        coproc_busy_pin = 1'b0;
        // Control nibble is protected, overflow, out of range, privilege change
        add(40'h0f9cc0, 3, 4'h0, K_STORE, 4, 0, 0); add(40'h0f9e00, 3, 4'h0, K_STORE, 5, 0, 0);
        add(40'h0f9fc1, 3, 4'h8, K_STORE, 4, 0, 0);
        add(40'hc8100000, 4, 0, K_FRAME_BUILD, 10, 0, 0); add(40'hc8100001, 4, 0, K_FRAME_BUILD, 12, 0, 0);
        add(40'hc8100003, 4, 4'h8, K_FRAME_BUILD, 23, 0, 0);
        add(40'hc8100002, 4, 0, K_FRAME_BUILD, 19, 0, 0);
        add(40'hc9, 1, 0, K_FRAME_TEARDOWN, 4, 0, 0); add(40'hc9, 1, 4'h8, K_FRAME_TEARDOWN, 4, 0, 0);
        add(40'hcd21, 2, 0, K_TRAP, 37, 1, 8'h21);
        add(40'hcc, 1, 0, K_TRAP, 33, 1, 8'h03);
        add(40'hce, 1, 4'h4, K_TRAP, 35, 1, 8'h04); add(40'hce, 1, 0, K_TRAP, 3, 0, 0);
        add(40'h62c0, 2, 4'h2, K_RANGE, 44, 1, 8'h05); add(40'h62c0, 2, 0, K_RANGE, 10, 0, 0);
        add(40'hcd30, 2, 4'h8, K_TRAP, 59, 1, 8'h30); add(40'hcd30, 2, 4'h9, K_TRAP, 99, 1, 8'h30);
        add(40'h0f20c0, 3, 0, K_CR_READ, 6, 0, 0);
        add(40'h0f23c0, 3, 0, K_DR_WRITE, 22, 0, 0); add(40'h0f23f8, 3, 0, K_DR_WRITE, 16, 0, 0);
        add(40'h0f21f8, 3, 0, K_DR_READ, 14, 0, 0);
        add(40'h0f21c0, 3, 0, K_DR_READ, 22, 0, 0);
        // Unknown opcode falls back to the default cost
        add(40'h01, 1, 0, K_OTHER, 2, 0, 0);
        add(40'h0f26c0, 3, 0, K_TR_WRITE, 12, 0, 0); add(40'h0f24c0, 3, 4'h8, K_TR_READ, 12, 0, 0);
        add(40'h90, 1, 0, K_IDLE, 3, 0, 0); add(40'h9b, 1, 0, K_SYNC, 7, 0, 0);
        add(40'h63c0, 2, 4'h8, K_PRIV_ADJUST, 20, 0, 0); add(40'h6300, 2, 4'h8, K_PRIV_ADJUST, 21, 0, 0);
        add(40'h0f02c0, 3, 4'h8, K_RIGHTS, 15, 0, 0); add(40'h0f0200, 3, 4'h8, K_RIGHTS, 16, 0, 0);
        add(40'h0f01d0, 3, 0, K_GLOBAL, 11, 0, 0); add(40'h0f0118, 3, 4'h8, K_VECTOR, 11, 0, 0);
        add(40'h0f00d0, 3, 4'h8, K_LOCAL, 20, 0, 0); add(40'h0f0010, 3, 4'h8, K_LOCAL, 24, 0, 0);
        add(40'h0f01f0, 3, 0, K_STATUS, 11, 0, 0); add(40'h0f0130, 3, 4'h8, K_STATUS, 14, 0, 0);
        // Kind left open on faults: only vector, cost and trap are pinned down
        add(40'h63c0, 2, 0, K_NONE, 1, 1, 8'h06); add(40'h0f0200, 3, 0, K_NONE, 1, 1, 8'h06);
        add(40'h0f00d0, 3, 0, K_NONE, 1, 1, 8'h06);
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK({issue_valid, busy, bus_lock, done, byte_ready}, 5'b00001)
        `CHK(issue, issue_s'(0))
        $display("test reset done");
        foreach (rows[i]) begin
            {protected_mode, overflow_flag, range_out, gate_priv_change} <= rows[i].ctl;
            run(rows[i].b, rows[i].n);
            if (rows[i].k != K_NONE) `CHK(got.kind, rows[i].k)
            `CHK(got.clocks, rows[i].c)
            `CHK(gap, int'(rows[i].c) - 1)
            `CHK(got.trap, rows[i].tr)
            if (rows[i].tr) `CHK(got.vector, rows[i].v)
        end
        protected_mode <= 1'b0;
        $display("test table done");
        run(40'h66672ef090, 5);
        `CHK(got.prefix, prefix_s'(7'h79))
        `CHK(got.clocks, 9'd3)
        `CHK(lk, 1'b1)
        @(posedge clk);
        `CHK(bus_lock, 1'b0)
        run(40'h90, 1);
        `CHK(got.prefix, prefix_s'(0))
        for (int i = 0; i < 6; i++) begin
            run(40'({segs[i], 8'h90}), 2);
            `CHK(got.prefix.seg, 3'(i))
            `CHK(got.prefix.seg_valid, 1'b1)
        end
        $display("test prefixes done");
        current_privilege <= 2'h3;
        io_privilege_ceiling <= 2'h1;
        run(40'hf090, 2);
        `CHK({got.trap, got.vector, got.clocks}, {1'b1, 8'h0d, 9'd1})
        current_privilege <= 2'h1;
        run(40'hf090, 2);
        `CHK(got.trap, 1'b0)
        run(40'hdee9, 2);
        `CHK({got.kind, got.coproc_op_hi, got.coproc_op_lo}, {K_COPROC, 3'h6, 3'h5})
        // Busy line released well after issue, so the stall must stretch the count
        coproc_busy_pin <= 1'b1;
        fork
            begin
                repeat (40) @(posedge clk);
                coproc_busy_pin <= 1'b0;
            end
        join_none
        run(40'h9b, 1);
        `CHK((gap >= 30) && (gap <= 50), 1'b1)
        $display("test lock, handoff and sync done");
        put(8'hc8); put(8'h10); put(8'h00); put(8'h03);
        byte_valid <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK({busy, byte_ready}, 2'b10)
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK({issue_valid, busy, bus_lock, done, byte_ready}, 5'b00001)
        srst <= 1'b0;
        run(40'h90, 1);
        `CHK(got.clocks, 9'd3)
        $display("test mid-run reset done");
        report_and_stop();
    end

    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
